// >>> drum_defines.svh
// Constants shared by the drum sector transfer control design.
// How it works
// - Transfers move whole 256-word sectors only.
// - Host words are 18 bits parallel, drum serial.
// - Capacity of 128, 256 or 512 blocks.
// - Host loads the core start address by command.
// - Core address counts up after each word.
// - Host loads the track and sector address.
// - Write setup requests the first word fetch.
// - Each drum word carries one added parity bit.
// - Next fetch follows each written word.
// - Completion flag sets after a written sector.
// - Track address increments at sector end.
// - Each read word is stored by break cycle.
// - Completion flag sets after a read sector.
// - Read words are parity checked.
// - Late host word on write is timing error.
// - Unstored read word overrun is timing error.
// - Gained or lost bits give data error.
// - Error flags hold until host clears them.
// - One sector takes one drum revolution.
// - Word transfers steal cycles without program help.
// - Parity makes the count of ones odd.
// - Track advances only with no data/parity error.
// - Core location counter is 16 bits.
// - Track register 9 bits, low bit sector.
`ifndef DRUM_DEFINES_SVH
`define DRUM_DEFINES_SVH

// ----------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------
`define WORD_BITS     18
`define DRUM_BITS     19
`define CORE_BITS     16
`define TRACK_BITS    9
`define CNT_BITS      9
`define BIT_CNT_BITS  5
`define TIMER_BITS    21
`define CMD_BITS      2
`define SECTOR_WORDS  9'h100
`define LAST_WORD     9'h0ff
`define LAST_DATA_BIT 5'h12
`define GAP_BIT       5'h13
`define FILL_WORD     19'h0_0001

// ----------------------------------------------------------------------
// Host command codes
// ----------------------------------------------------------------------
`define CMD_LOAD_CORE   2'h0
`define CMD_SETUP_READ  2'h1
`define CMD_SETUP_WRITE 2'h2
`define CMD_CLEAR       2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define REV_TIME_NS   17300000

`endif

// >>> drum_pkg.sv
// Types shared by the drum sector transfer control design.
`include "drum_defines.svh"

package drum_pkg;

  typedef struct packed {
    logic [`CMD_BITS-1:0]  code;
    logic [`WORD_BITS-1:0] data;
  } host_cmd_type;

  typedef struct packed {
    logic [`CORE_BITS-1:0] addr;
    logic [`WORD_BITS-1:0] data;
    logic                  store;
  } break_type;

  typedef enum logic [1:0] {IDLE_ST, WAIT_ST, XFER_ST, FIN_ST} state_type;

endpackage : drum_pkg

// >>> pin_sync.sv
// Three-stage synchroniser for drum pins; output follows once stages two and three agree.
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output      logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] q_next;

  assign agree  = s2_reg ~^ s3_reg;
  assign q_next = (agree & s3_reg) | (~agree & q_reg);
  assign q      = q_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

endmodule : pin_sync

// >>> word_buffer.sv
// Two-entry word buffer with valid and ready on both sides.
`timescale 1ns/1ps

module word_buffer #(
  parameter int WIDTH = 19
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] head_reg;
  logic [WIDTH-1:0] tail_reg;
  logic [1:0]       count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = head_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_reg  <= '0;
      tail_reg  <= '0;
      count_reg <= 2'h0;
    end else if (flush) begin
      count_reg <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count_reg == 2'h0) head_reg <= in_data;
          else tail_reg <= in_data;
          count_reg <= count_reg + 2'h1;
        end
        2'b01: begin
          head_reg  <= tail_reg;
          count_reg <= count_reg - 2'h1;
        end
        2'b11: begin
          head_reg <= (count_reg == 2'h1) ? in_data : tail_reg;
          tail_reg <= in_data;
        end
        default: begin
          count_reg <= count_reg;
        end
      endcase
    end
  end

endmodule : word_buffer

// >>> drum_sector_transfer_control.sv
// Sector transfer control between host core memory and a serial drum.
`timescale 1ns/1ps
`include "drum_defines.svh"

module drum_sector_transfer_control
  import drum_pkg::*;
#(
  parameter int BLOCKS     = 512,
  parameter int REV_CYCLES = `REV_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   io_transfer_instruction,
  input  wire host_cmd_type           host_cmd,
  output      logic                   break_req,
  input  wire logic                   break_ack,
  input  wire logic [`WORD_BITS-1:0]  break_read_data,
  output      break_type              break_out,
  output      logic [`TRACK_BITS-1:0] track_address,
  output      logic                   done_flag,
  output      logic                   data_error,
  output      logic                   parity_error,
  output      logic                   timing_error,
  input  wire logic                   drum_clock,
  input  wire logic                   drum_index,
  input  wire logic                   drum_read_bit,
  input  wire logic                   drum_read_strobe,
  output      logic                   drum_write_bit,
  output      logic                   drum_write_enable
);

  localparam logic [`TRACK_BITS-1:0] TRACK_MASK = `TRACK_BITS'(BLOCKS - 1);
  localparam logic [`TIMER_BITS-1:0] XFER_LIMIT = `TIMER_BITS'(2 * REV_CYCLES);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  state_type                state_reg;
  state_type                state_next;
  logic [`CORE_BITS-1:0]    core_location_counter;
  logic [`TRACK_BITS-1:0]   track_reg;
  logic                     read_dir_reg;
  logic                     break_req_reg;
  logic [`CNT_BITS-1:0]     fetch_cnt_reg;
  logic [`CNT_BITS-1:0]     deliver_cnt_reg;
  logic [`CNT_BITS-1:0]     word_cnt_reg;
  logic [`BIT_CNT_BITS-1:0] bit_cnt_reg;
  logic [`BIT_CNT_BITS-1:0] sense_cnt_reg;
  logic [`TRACK_BITS-1:0]   slot_reg;
  logic [`DRUM_BITS-1:0]    shift_reg;
  logic [`DRUM_BITS-1:0]    shift_next;
  logic [`TIMER_BITS-1:0]   timer_reg;
  logic                     clk_prev_reg;
  logic                     idx_prev_reg;
  logic                     done_reg;
  logic                     data_error_reg;
  logic                     parity_error_reg;
  logic                     timing_error_reg;
  logic                     wbit_reg;
  logic                     wen_reg;

  // ----------------------------------------------------------------------
  // Pin synchronisers and drum event decode
  // ----------------------------------------------------------------------
  logic [3:0] pins_q;
  logic       clk_q;
  logic       idx_q;
  logic       rbit_q;
  logic       strobe_q;
  logic       clk_pulse;
  logic       idx_pulse;
  logic       our_pulse;
  logic       bit_act;
  logic       word_start;
  logic       slot_end;
  logic       words_left;

  pin_sync #(.WIDTH(4)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({drum_read_strobe, drum_read_bit, drum_index, drum_clock}),
    .q     (pins_q)
  );

  assign clk_q      = pins_q[0];
  assign idx_q      = pins_q[1];
  assign rbit_q     = pins_q[2];
  assign strobe_q   = pins_q[3];
  assign clk_pulse  = clk_q && !clk_prev_reg;
  assign idx_pulse  = idx_q && !idx_prev_reg;
  // Words of one sector sit in every other slot; the low track bit picks which.
  assign our_pulse  = clk_pulse && (state_reg == XFER_ST) && (slot_reg[0] == track_reg[0]);
  assign bit_act    = our_pulse && (bit_cnt_reg <= `LAST_DATA_BIT);
  assign words_left = (word_cnt_reg != `SECTOR_WORDS);
  assign word_start = our_pulse && (bit_cnt_reg == 5'h00) && words_left;
  assign slot_end   = our_pulse && (bit_cnt_reg == `GAP_BIT) && words_left;

  // ----------------------------------------------------------------------
  // Host command decode
  // ----------------------------------------------------------------------
  logic cmd_core;
  logic cmd_setup;
  logic cmd_clear;

  assign cmd_core  = io_transfer_instruction && (host_cmd.code == `CMD_LOAD_CORE);
  assign cmd_setup = io_transfer_instruction &&
                     ((host_cmd.code == `CMD_SETUP_READ) || (host_cmd.code == `CMD_SETUP_WRITE));
  assign cmd_clear = io_transfer_instruction && (host_cmd.code == `CMD_CLEAR);

  // ----------------------------------------------------------------------
  // Word buffer in the data path, steered by direction
  // ----------------------------------------------------------------------
  logic                  buf_in_valid;
  logic                  buf_in_ready;
  logic [`DRUM_BITS-1:0] buf_in_data;
  logic                  buf_out_valid;
  logic                  buf_out_ready;
  logic [`DRUM_BITS-1:0] buf_out_data;
  logic                  ack_take;
  logic [`DRUM_BITS-1:0] load_word;
  logic                  sensed_total_ok;
  logic                  read_parity_bad;
  logic                  write_late;
  logic                  read_overrun;
  logic                  write_done;
  logic                  read_done;
  logic                  timeout;
  logic                  fetch_want;

  assign ack_take      = break_req_reg && break_ack;
  // Odd parity: the added bit makes the ones count of the stored word odd.
  assign buf_in_data   = read_dir_reg ? shift_reg : {break_read_data, ~^break_read_data};
  assign buf_in_valid  = read_dir_reg ? slot_end : (ack_take && !read_dir_reg);
  assign buf_out_ready = read_dir_reg ? ack_take : word_start;
  assign load_word     = buf_out_valid ? buf_out_data : `FILL_WORD;
  assign write_late    = !read_dir_reg && word_start && !buf_out_valid;
  assign read_overrun  = read_dir_reg && slot_end && !buf_in_ready;
  assign sensed_total_ok = ((sense_cnt_reg + {4'h0, strobe_q}) == `BIT_CNT_BITS'(`DRUM_BITS));
  assign read_parity_bad = read_dir_reg && slot_end && !(^shift_reg);
  assign write_done    = !read_dir_reg && slot_end && (word_cnt_reg == `LAST_WORD);
  assign read_done     = read_dir_reg && (deliver_cnt_reg == `SECTOR_WORDS);
  assign timeout       = (timer_reg >= XFER_LIMIT);
  assign fetch_want    = !read_dir_reg && (fetch_cnt_reg != `SECTOR_WORDS) &&
                         buf_in_ready && (state_reg != IDLE_ST);
  assign shift_next    = read_dir_reg ? {shift_reg[`DRUM_BITS-2:0], rbit_q} :
                         (word_start ? load_word : {shift_reg[`DRUM_BITS-2:0], 1'b0});

  word_buffer #(.WIDTH(`DRUM_BITS)) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (cmd_setup),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE_ST: state_next = IDLE_ST;
      WAIT_ST: if (idx_pulse) state_next = XFER_ST;
      XFER_ST: if (write_done || read_done) state_next = FIN_ST;
      FIN_ST:  state_next = IDLE_ST;
      default: state_next = IDLE_ST;
    endcase
    if (timeout && (state_reg != IDLE_ST)) state_next = IDLE_ST;
    if (cmd_setup) state_next = WAIT_ST;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= IDLE_ST;
      read_dir_reg <= 1'b0;
      timer_reg    <= '0;
    end else begin
      state_reg <= state_next;
      if (cmd_setup) read_dir_reg <= (host_cmd.code == `CMD_SETUP_READ);
      timer_reg <= (state_next == WAIT_ST || state_next == XFER_ST) && !cmd_setup ?
                   timer_reg + `TIMER_BITS'(1) : '0;
    end
  end

  // ----------------------------------------------------------------------
  // Address registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_location_counter <= '0;
      track_reg             <= '0;
    end else begin
      if (cmd_core) core_location_counter <= host_cmd.data[`CORE_BITS-1:0];
      else if (ack_take) core_location_counter <= core_location_counter + 16'h0001;
      if (cmd_setup) track_reg <= host_cmd.data[`TRACK_BITS-1:0] & TRACK_MASK;
      else if (state_reg == FIN_ST && !data_error_reg && !parity_error_reg)
        track_reg <= (track_reg + 9'h001) & TRACK_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // Data break requests
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      break_req_reg   <= 1'b0;
      fetch_cnt_reg   <= '0;
      deliver_cnt_reg <= '0;
    end else if (cmd_setup) begin
      break_req_reg   <= 1'b0;
      fetch_cnt_reg   <= '0;
      deliver_cnt_reg <= '0;
    end else begin
      if (ack_take || state_reg == IDLE_ST) break_req_reg <= 1'b0;
      else if (!break_req_reg)
        break_req_reg <= fetch_want || (read_dir_reg && buf_out_valid);
      if (ack_take && !read_dir_reg) fetch_cnt_reg <= fetch_cnt_reg + 9'h001;
      if (ack_take && read_dir_reg) deliver_cnt_reg <= deliver_cnt_reg + 9'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Drum position tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_reg <= 1'b0;
      idx_prev_reg <= 1'b0;
      bit_cnt_reg  <= '0;
      slot_reg     <= '0;
    end else begin
      clk_prev_reg <= clk_q;
      idx_prev_reg <= idx_q;
      if (idx_pulse) begin
        bit_cnt_reg <= '0;
        slot_reg    <= '0;
      end else if (clk_pulse) begin
        if (bit_cnt_reg == `GAP_BIT) begin
          bit_cnt_reg <= '0;
          slot_reg    <= slot_reg + 9'h001;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial word shifting, both directions
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg     <= '0;
      sense_cnt_reg <= '0;
      word_cnt_reg  <= '0;
      wbit_reg      <= 1'b0;
      wen_reg       <= 1'b0;
    end else if (cmd_setup) begin
      sense_cnt_reg <= '0;
      word_cnt_reg  <= '0;
      wen_reg       <= 1'b0;
    end else begin
      if (bit_act) shift_reg <= shift_next;
      if (bit_act && !read_dir_reg) wbit_reg <= shift_next[`DRUM_BITS-1];
      if (state_reg != XFER_ST) wen_reg <= 1'b0;
      else if (clk_pulse) wen_reg <= bit_act && !read_dir_reg;
      if (slot_end) sense_cnt_reg <= '0;
      else if (our_pulse && strobe_q) sense_cnt_reg <= sense_cnt_reg + 5'h01;
      if (slot_end) word_cnt_reg <= word_cnt_reg + 9'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Completion and error flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg         <= 1'b0;
      data_error_reg   <= 1'b0;
      parity_error_reg <= 1'b0;
      timing_error_reg <= 1'b0;
    end else begin
      if (cmd_clear || cmd_setup) begin
        done_reg         <= 1'b0;
        data_error_reg   <= 1'b0;
        parity_error_reg <= 1'b0;
        timing_error_reg <= 1'b0;
      end
      if (state_reg == FIN_ST || (timeout && state_reg != IDLE_ST)) done_reg <= 1'b1;
      if (read_dir_reg && slot_end && !sensed_total_ok) data_error_reg <= 1'b1;
      if (read_parity_bad) parity_error_reg <= 1'b1;
      if (write_late || read_overrun || (timeout && state_reg != IDLE_ST))
        timing_error_reg <= 1'b1;
    end
  end

  assign break_req         = break_req_reg;
  assign break_out.addr    = core_location_counter;
  assign break_out.data    = buf_out_data[`DRUM_BITS-1:1];
  assign break_out.store   = read_dir_reg;
  assign track_address     = track_reg;
  assign done_flag         = done_reg;
  assign data_error        = data_error_reg;
  assign parity_error      = parity_error_reg;
  assign timing_error      = timing_error_reg;
  assign drum_write_bit    = wbit_reg;
  assign drum_write_enable = wen_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_core_incr: assert property (
    ack_take && !cmd_core |=> core_location_counter == $past(core_location_counter) + 16'h0001)
    else $error("core counter did not step after a break cycle");
  a_parity_odd: assert property (
    word_start && !read_dir_reg && !cmd_setup |=> ^shift_reg)
    else $error("word loaded for the drum has even parity");
  a_track_adv: assert property (
    state_reg == FIN_ST && !data_error_reg && !parity_error_reg && !cmd_setup
    |=> track_reg == (($past(track_reg) + 9'h001) & TRACK_MASK))
    else $error("track did not advance after a clean sector");
  a_track_hold: assert property (
    state_reg == FIN_ST && (data_error_reg || parity_error_reg) && !cmd_setup |=> $stable(track_reg))
    else $error("track advanced after an erroneous sector");
  a_done_set: assert property (
    state_reg == FIN_ST && !cmd_setup |=> done_reg && state_reg == IDLE_ST)
    else $error("completion flag missing at sector end");
  a_word_limit: assert property (
    word_cnt_reg <= `SECTOR_WORDS && fetch_cnt_reg <= `SECTOR_WORDS)
    else $error("more than one sector of words moved");
  a_late_write: assert property (
    write_late && !cmd_setup |=> timing_error_reg)
    else $error("late host word not flagged");
  a_read_overrun: assert property (
    read_overrun && !cmd_setup |=> timing_error_reg)
    else $error("read overrun not flagged");
  a_parity_check: assert property (
    read_parity_bad && !cmd_setup |=> parity_error_reg)
    else $error("read parity error not flagged");
  a_req_hold: assert property (
    break_req_reg && !break_ack && state_reg != IDLE_ST && !cmd_setup |=> break_req_reg)
    else $error("break request dropped before acknowledge");
  a_track_range: assert property (
    (track_reg & ~TRACK_MASK) == '0)
    else $error("track address beyond configured capacity");

endmodule : drum_sector_transfer_control

// >>> host_break_model.sv
// Host data break responder that fetches and stores words for the drum control.
`timescale 1ns/1ps
`include "drum_defines.svh"

module host_break_model
  import drum_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  stall,
  input  wire logic                  break_req,
  input  wire break_type             break_out,
  output      logic                  break_ack,
  output      logic [`WORD_BITS-1:0] break_read_data,
  output      int                    n_acks,
  output      logic [`WORD_BITS-1:0] last_store
);
  // Outside an acknowledge the read data toggles, so a stale word is never mistaken for valid.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      break_ack       <= 1'b0;
      break_read_data <= 18'h0_0000;
      n_acks          <= 0;
      last_store      <= 18'h0_0000;
    end else if (break_req && !break_ack && !stall) begin
      break_ack       <= 1'b1;
      break_read_data <= {2'b10, break_out.addr};
      n_acks          <= n_acks + 1;
      if (break_out.store) begin
        last_store <= break_out.data;
      end
    end else begin
      break_ack       <= 1'b0;
      break_read_data <= ~break_read_data;
    end
  end
endmodule : host_break_model

// >>> tb_top.sv
// Self-checking testbench for the drum sector transfer control.
`timescale 1ns/1ps
`include "drum_defines.svh"

module tb_top
  import drum_pkg::*;
;
  logic clk, rst_n, io_transfer_instruction, break_req, break_ack, stall;
  logic done_flag, data_error, parity_error, timing_error, drum_write_bit, drum_write_enable;
  logic drum_clock, drum_index, drum_read_bit, drum_read_strobe;
  host_cmd_type host_cmd;
  break_type break_out;
  logic [17:0] break_read_data, last_store;
  logic [8:0] track_address;
  logic [18:0] cap;
  int n_acks, n_errors, compares, n_wen;

  drum_sector_transfer_control #(.BLOCKS(512), .REV_CYCLES(40000)) drum_sector_transfer_control_inst (
    .clk, .rst_n, .io_transfer_instruction, .host_cmd, .break_req, .break_ack, .break_read_data,
    .break_out, .track_address, .done_flag, .data_error, .parity_error, .timing_error,
    .drum_clock, .drum_index, .drum_read_bit, .drum_read_strobe, .drum_write_bit,
    .drum_write_enable);

  host_break_model host_break_model_inst (.clk, .rst_n, .stall, .break_req, .break_out,
    .break_ack, .break_read_data, .n_acks, .last_store);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic cmd(input logic [1:0] code, input logic [17:0] data);
    io_transfer_instruction = 1'b1;
    host_cmd = {code, data};
    cyc(1);
    io_transfer_instruction = 1'b0;
    cyc(1);
  endtask : cmd

  // One drum clock pulse, or an index pulse when idx is set; the write pins are sampled just before the next pulse.
  task automatic pulse(input logic b, input logic s, input logic idx);
    drum_read_bit = b;
    drum_read_strobe = s;
    drum_clock = !idx;
    drum_index = idx;
    cyc(3);
    drum_clock = 1'b0;
    drum_index = 1'b0;
    cyc(3);
    if (drum_write_enable === 1'b1) begin
      n_wen++;
      cap = {cap[17:0], drum_write_bit};
    end
  endtask : pulse

  task automatic slot(input logic [18:0] w, input int miss);
    for (int b = 0; b < 20; b++) begin
      pulse(b < 19 ? w[18-b] : 1'b0, b < 19 && b != miss, 1'b0);
    end
  endtask : slot

  task automatic late_word();
    stall = 1'b1;
    cmd(2'h2, 18'h0_0000);
    pulse(1'b0, 1'b0, 1'b1);
    pulse(1'b0, 1'b0, 1'b0);
    chk("break_req", break_req, 1);
    chk("timing_error", timing_error, 1);
  endtask : late_word

  task automatic write_sector();
    int base;
    cmd(2'h0, 18'h0_0100);
    cmd(2'h2, 18'h0_00a4);
    stall = 1'b0;
    base = n_acks;
    chk("timing_error", timing_error, 0);
    chk("track_address", track_address, 9'h0a4);
    pulse(1'b0, 1'b0, 1'b1);
    n_wen = 0;
    for (int s = 0; s < 512; s++) begin
      slot(19'h0_0000, 0);
      if (s == 0) chk("first_word", cap, {18'h2_0100, ~^18'h2_0100});
    end
    chk("done_flag", done_flag, 1);
    chk("track_address", track_address, 9'h0a5);
    chk("fetch_count", n_acks - base, 256);
    chk("core_address", break_out.addr, 16'h0200);
    chk("write_bits", n_wen, 4864);
    chk("store_dir", break_out.store, 0);
  endtask : write_sector

  task automatic read_sector();
    logic [17:0] w;
    int base;
    w = 18'h2_5a5a;
    cmd(2'h0, 18'h0_0400);
    cmd(2'h1, 18'h0_0033);
    base = n_acks;
    chk("done_flag", done_flag, 0);
    pulse(1'b0, 1'b0, 1'b1);
    slot(19'h0_0000, 19);
    slot({w, ~^w}, 19);
    slot(19'h0_0000, 19);
    chk("stored_word", last_store, w);
    chk("store_count", n_acks - base, 1);
    chk("core_address", break_out.addr, 16'h0401);
    chk("store_dir", break_out.store, 1);
    chk("parity_error", parity_error, 0);
    slot({w, ^w}, 19);
    chk("parity_error", parity_error, 1);
    slot(19'h0_0000, 19);
    slot({w, ~^w}, 7);
    chk("data_error", data_error, 1);
    cyc(20);
    chk("parity_error", parity_error, 1);
    cmd(2'h3, 18'h0_0000);
    chk("data_error", data_error, 0);
    chk("parity_error", parity_error, 0);
  endtask : read_sector

  // A stalled host lets two read words fill the buffer; the third is an overrun.
  task automatic read_overrun();
    logic [17:0] w;
    w = 18'h1_c3c3;
    chk("timing_error", timing_error, 0);
    stall = 1'b1;
    for (int k = 0; k < 3; k++) begin
      slot(19'h0_0000, 19);
      slot({w, ~^w}, 19);
    end
    chk("timing_error", timing_error, 1);
    chk("break_req", break_req, 1);
  endtask : read_overrun

  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    conclude();
  end

  initial begin
    io_transfer_instruction = 1'b0;
    host_cmd = '0;
    stall = 1'b0;
    drum_clock = 1'b0;
    drum_index = 1'b0;
    drum_read_bit = 1'b0;
    drum_read_strobe = 1'b0;
    rst_n = 1'b0;
    n_errors = 0;
    compares = 0;
    n_wen = 0;
    cap = '0;
    cyc(10);
    rst_n = 1'b1;
    cyc(1);
    chk("done_flag", done_flag, 0);
    late_word();
    write_sector();
    read_sector();
    read_overrun();
    conclude();
  end
endmodule : tb_top
